/* File: hw/scsf_top.sv */
// Notes on behaviour
// - A received byte whose one-count with its parity bit misses the selected odd or even parity sets the parity flag while receive-full is clear.
// - On a parity error the byte still goes to the receive holding register but receive-full stays clear.
// - While the parity flag is set reception stops, and in synchronous mode transmission is blocked too.
// - The error-signal flag sets when the card's error signal is sampled as a low line level.
// - Clearing transmit enable leaves the error-signal flag as it was.
// - A reception completing while receive-full is set raises overrun, keeps the old byte and drops the new one.
// - While the overrun flag is set reception stops, and in synchronous mode transmission is blocked too.
// - Clearing receive enable leaves the overrun flag as it was.
// - Receive-full keeps its value when a reception error occurs or receive enable is cleared.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module scsf_top
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       rx_done,
    input  wire logic [7:0] rx_shift_reg,
    input  wire logic       rx_parity,
    input  wire logic       err_sample,
    input  wire logic       line_in,
    input  wire logic       tx_load,
    output logic      [7:0] tx_holding_reg,
    output logic            tx_valid,
    output logic            rx_enable_bit,
    output logic            tx_enable_bit,
    output logic            rx_halt,
    output logic            tx_block,
    output logic            irq
);

    // ****************************************************************
    // Reset release through two flip-flops.
    // ****************************************************************
    logic rst_meta;
    logic rst_n;

    // Assertion is immediate, release waits two clock edges.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************************************
    // Register state.
    // ****************************************************************
    scsf_pkg::scsf_req_t   req;
    scsf_pkg::scsf_flags_t flags;
    scsf_pkg::scsf_flags_t read_seen;
    scsf_pkg::scsf_flags_t irq_stat;
    scsf_pkg::scsf_flags_t irq_mask;
    logic [scsf_pkg::CTL_WIDTH-1:0] control;
    logic [7:0]                     rx_holding_reg;

    // Bundle the register port.
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // Returns true when a register access hits the given offset.
    function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] ofs);
        hit = strobe && (a == ofs);
    endfunction : hit

    // ****************************************************************
    // Address decode.
    // ****************************************************************
    wire wr_status  = hit(req.wr, req.addr, scsf_pkg::OFS_STATUS);
    wire wr_control = hit(req.wr, req.addr, scsf_pkg::OFS_CONTROL);
    wire wr_tx_data = hit(req.wr, req.addr, scsf_pkg::OFS_TX_DATA);
    wire wr_irq     = hit(req.wr, req.addr, scsf_pkg::OFS_IRQ_STAT);
    wire wr_mask    = hit(req.wr, req.addr, scsf_pkg::OFS_IRQ_MASK);
    wire rd_status  = hit(req.rd, req.addr, scsf_pkg::OFS_STATUS);

    // ****************************************************************
    // Control bits.
    // ****************************************************************
    wire rx_en    = control[scsf_pkg::CTL_RX_ENABLE];
    wire tx_en    = control[scsf_pkg::CTL_TX_ENABLE];
    wire odd_par  = control[scsf_pkg::CTL_ODD];

    // ****************************************************************
    // Reception events.
    // ****************************************************************
    // Reception is frozen while the parity or overrun flag is up.
    wire halted    = flags.parity_error_flag | flags.overrun_flag;
    wire rx_take   = rx_done && rx_en && !halted;
    // Even parity wants an even one-count, odd parity an odd one.
    wire par_bad   = (^{rx_shift_reg, rx_parity}) != odd_par;
    wire ev_parity = rx_take && par_bad && !flags.rx_full_flag;
    wire ev_over   = rx_take && flags.rx_full_flag;
    wire ev_full   = rx_take && !par_bad && !flags.rx_full_flag;
    wire rx_store  = rx_take && !flags.rx_full_flag;
    // Error signal from the card shows as a low line at the sample point.
    wire ev_errsig = err_sample && !line_in;
    wire ev_txe    = tx_load || !tx_en;

    // ****************************************************************
    // Clear by writing 0 after reading 1; a set in the same cycle wins.
    // ****************************************************************
    wire [4:0] sw_clear = wr_status ? (~req.wdata[4:0] & read_seen) : 5'h00;
    // Set events by flag name, so the bit order lives in the struct alone.
    scsf_pkg::scsf_flags_t ev_vec;
    scsf_pkg::scsf_flags_t hw_clear;
    assign ev_vec = '{tx_empty_flag: ev_txe, rx_full_flag: ev_full, overrun_flag: ev_over,
                      error_signal_flag: ev_errsig, parity_error_flag: ev_parity};
    // Writing transmit data while transmit is enabled also clears the transmit-empty flag.
    assign hw_clear = '{tx_empty_flag: wr_tx_data && tx_en, default: 1'b0};
    // Receive enable only gates set events and a clear transmit enable sets transmit-empty; other flags hold when enables drop.
    wire [4:0] next_flags = ev_vec | (flags & ~sw_clear & ~hw_clear);
    // Typed copy of the next flags, so outputs pick their field by name.
    scsf_pkg::scsf_flags_t next_fl;
    assign next_fl = next_flags;

    // Remembers which flags were read as 1 until a status write uses it.
    wire [4:0] next_seen = rd_status ? (read_seen | flags) :
                           (wr_status ? 5'h00 : read_seen) & next_flags;

    // Interrupt status: set by a rising flag, cleared by writing 1.
    wire [4:0] rise     = next_flags & ~flags;
    wire [4:0] irq_clr  = wr_irq ? req.wdata[4:0] : 5'h00;
    wire [4:0] next_irq = rise | (irq_stat & ~irq_clr);

    // ****************************************************************
    // Read data selection.
    // ****************************************************************
    wire [7:0] next_rdata =
        !req.rd                                       ? 8'h00 :
        (req.addr == scsf_pkg::OFS_STATUS)            ? {3'h0, flags} :
        (req.addr == scsf_pkg::OFS_CONTROL)           ? {4'h0, control} :
        (req.addr == scsf_pkg::OFS_RX_DATA)           ? rx_holding_reg :
        (req.addr == scsf_pkg::OFS_TX_DATA)           ? tx_holding_reg :
        (req.addr == scsf_pkg::OFS_IRQ_STAT)          ? {3'h0, irq_stat} :
        (req.addr == scsf_pkg::OFS_IRQ_MASK)          ? {3'h0, irq_mask} :
                                                        8'h00;

    // ****************************************************************
    // Output terms from the next state.
    // ****************************************************************
    // Halt and block come from the next flags, so they move in the same cycle as the flags.
    wire                           next_halt  = next_fl.parity_error_flag | next_fl.overrun_flag;
    wire [scsf_pkg::CTL_WIDTH-1:0] next_ctl   = wr_control ? req.wdata[scsf_pkg::CTL_WIDTH-1:0] : control;
    wire                           next_block = next_halt && next_ctl[scsf_pkg::CTL_SYNC];
    wire                           next_txv   = !next_fl.tx_empty_flag;
    // A mask written in this cycle already gates the interrupt output of the next.
    wire [4:0]                     next_mask  = wr_mask ? req.wdata[4:0] : irq_mask;
    wire                           next_irq_o = |(next_irq & next_mask);
    // A byte that meets a full holding register is dropped here.
    wire [7:0]                     next_rx_data = rx_store ? rx_shift_reg : rx_holding_reg;
    wire [7:0]                     next_tx_data = wr_tx_data ? req.wdata : tx_holding_reg;

    // ****************************************************************
    // Flags and interrupt state.
    // ****************************************************************
    // Status flags follow the merged set and clear terms.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags <= scsf_pkg::FLAGS_RESET;
        end
        else
        begin
            flags <= next_flags;
        end
    end

    // Read marks that allow a later zero write to clear a flag.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            read_seen <= scsf_pkg::IRQ_RESET;
        end
        else
        begin
            read_seen <= next_seen;
        end
    end

    // Interrupt status and mask.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat <= scsf_pkg::IRQ_RESET;
            irq_mask <= scsf_pkg::MASK_RESET;
        end
        else
        begin
            irq_stat <= next_irq;
            irq_mask <= next_mask;
        end
    end

    // Interrupt output, a level from a flop.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= next_irq_o;
        end
    end

    // ****************************************************************
    // Control and data holding registers.
    // ****************************************************************
    // Control register.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control <= scsf_pkg::CONTROL_RESET;
        end
        else
        begin
            control <= next_ctl;
        end
    end

    // Receive holding register.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_holding_reg <= scsf_pkg::DATA_RESET;
        end
        else
        begin
            rx_holding_reg <= next_rx_data;
        end
    end

    // Transmit holding register.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_holding_reg <= scsf_pkg::DATA_RESET;
        end
        else
        begin
            tx_holding_reg <= next_tx_data;
        end
    end

    // ****************************************************************
    // Registered outputs.
    // ****************************************************************
    // Read data stand for one cycle after the read strobe.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= scsf_pkg::DATA_RESET;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

    // Holding byte present towards the transmitter.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_valid <= 1'b0;
        end
        else
        begin
            tx_valid <= next_txv;
        end
    end

    // Enable copies and the halt and block levels for the serial side.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_enable_bit <= 1'b0;
            tx_enable_bit <= 1'b0;
            rx_halt       <= 1'b0;
            tx_block      <= 1'b0;
        end
        else
        begin
            rx_enable_bit <= next_ctl[scsf_pkg::CTL_RX_ENABLE];
            tx_enable_bit <= next_ctl[scsf_pkg::CTL_TX_ENABLE];
            rx_halt       <= next_halt;
            tx_block      <= next_block;
        end
    end

endmodule : scsf_top

/* File: hw/scsf_pkg.sv */
package scsf_pkg;

    // ****************************************************************
    // Register offsets on the plain register port.
    // ****************************************************************
    localparam logic [2:0] OFS_STATUS   = 3'h0;
    localparam logic [2:0] OFS_CONTROL  = 3'h1;
    localparam logic [2:0] OFS_RX_DATA  = 3'h2;
    localparam logic [2:0] OFS_TX_DATA  = 3'h3;
    localparam logic [2:0] OFS_IRQ_STAT = 3'h4;
    localparam logic [2:0] OFS_IRQ_MASK = 3'h5;

    // ****************************************************************
    // Field positions of the control register.
    // ****************************************************************
    localparam int CTL_RX_ENABLE = 0;
    localparam int CTL_TX_ENABLE = 1;
    localparam int CTL_ODD       = 2;
    localparam int CTL_SYNC      = 3;
    localparam int CTL_WIDTH     = 4;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [4:0] FLAGS_RESET   = 5'h10;
    localparam logic [4:0] IRQ_RESET     = 5'h00;
    localparam logic [4:0] MASK_RESET    = 5'h00;

    // ****************************************************************
    // Status flags, bit 0 upward: parity, error signal, overrun,
    // receive full, transmit empty. Status, irq status and mask share it.
    // ****************************************************************
    typedef struct packed {
        logic tx_empty_flag;
        logic rx_full_flag;
        logic overrun_flag;
        logic error_signal_flag;
        logic parity_error_flag;
    } scsf_flags_t;

    // Register port request as one bundle.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } scsf_req_t;

endpackage : scsf_pkg

/* File: tb/scsf_chk.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checker of the smart card flag block.
// ****************************************************************
module scsf_chk
(
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       rx_done,
    input wire logic       tx_load,
    input wire logic       tx_valid,
    input wire logic       rx_enable_bit,
    input wire logic       tx_enable_bit,
    input wire logic       rx_halt,
    input wire logic       tx_block
);
    // Decoded status and transmit data writes.
    wire st_wr = reg_wr && reg_addr == scsf_pkg::OFS_STATUS;
    wire tx_wr = reg_wr && reg_addr == scsf_pkg::OFS_TX_DATA;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    AST_HALT_HOLD: assert property (rx_halt && !st_wr |=> rx_halt)
        else $error("halt left without a status write");
    AST_WR_ONES: assert property (rx_halt && st_wr && reg_wdata[2:0] == 3'h7 |=> rx_halt)
        else $error("writing ones released the halt");
    AST_HALT_CAUSE: assert property ($rose(rx_halt) |-> $past(rx_done))
        else $error("halt rose without a reception");
    AST_HALT_RXEN: assert property ($fell(rx_enable_bit) && $past(rx_halt) |-> rx_halt)
        else $error("receive disable cleared the halt");
    AST_BLOCK_HALT: assert property (tx_block |-> rx_halt)
        else $error("transmit blocked without a halt");
    AST_TXE_OFF: assert property (!tx_enable_bit ##1 !tx_enable_bit |=> !tx_valid)
        else $error("transmit byte held while transmit disabled");
    AST_LOAD_EMPTY: assert property (tx_load && !tx_wr |=> !tx_valid)
        else $error("holding byte kept after load");
    AST_TXW_FULL: assert property (tx_wr && tx_enable_bit && !tx_load |=> tx_valid)
        else $error("transmit write not taken");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule : scsf_chk
bind scsf_top scsf_chk i_chk
(
    .clk(clk),
    .arst_n(arst_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .rx_done(rx_done),
    .tx_load(tx_load),
    .tx_valid(tx_valid),
    .rx_enable_bit(rx_enable_bit),
    .tx_enable_bit(tx_enable_bit),
    .rx_halt(rx_halt),
    .tx_block(tx_block)
);

/* File: tb/scsf_card.sv */
`timescale 1ns/1ps
// ****************************************************************
// Card model: sends bytes, gives error signals, takes bytes.
// ****************************************************************
module scsf_card
(
    input  wire logic       clk,
    input  wire logic       c_send,
    input  wire logic       c_sig,
    input  wire logic       c_nak,
    input  wire logic       c_bad,
    input  wire logic       c_odd,
    input  wire logic       c_rdy,
    input  wire logic [7:0] c_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_block,
    output logic            rx_done = 1'b0,
    output logic      [7:0] rx_shift_reg = 8'h00,
    output logic            rx_parity = 1'b0,
    output logic            err_sample = 1'b0,
    output logic            line_in = 1'b1,
    output logic            tx_load = 1'b0
);
    // Lines flip every cycle outside their strobes, so stale values never match.
    always @(posedge clk)
    begin
        rx_done      <= c_send;
        rx_shift_reg <= c_send ? c_data : ~rx_shift_reg;
        rx_parity    <= c_send ? ^c_data ^ c_odd ^ c_bad : ~rx_parity;
        err_sample   <= c_sig;
        line_in      <= c_sig ? !c_nak : ~line_in;
        tx_load      <= c_rdy && tx_valid && !tx_block && !tx_load;
    end
endmodule : scsf_card

/* File: tb/scsf_top_test.sv */
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the smart card flag block.
// ****************************************************************
module scsf_top_test;
    localparam logic [2:0] ST = scsf_pkg::OFS_STATUS;
    localparam logic [2:0] CT = scsf_pkg::OFS_CONTROL;
    localparam logic [2:0] RX = scsf_pkg::OFS_RX_DATA;
    localparam logic [2:0] TX = scsf_pkg::OFS_TX_DATA;
    localparam logic [2:0] IS = scsf_pkg::OFS_IRQ_STAT;
    localparam logic [2:0] IM = scsf_pkg::OFS_IRQ_MASK;
    logic       clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, c_data = 8'h00, reg_rdata, rx_shift_reg, tx_holding_reg;
    logic       c_send = 1'b0, c_sig = 1'b0, c_nak = 1'b0, c_bad = 1'b0, c_odd = 1'b0, c_rdy = 1'b0;
    logic       rx_done, rx_parity, err_sample, line_in, tx_load, tx_valid;
    logic       rx_enable_bit, tx_enable_bit, rx_halt, tx_block, irq;
    int         err_total = 0, cmp_count = 0, cyc = 0;
    scsf_top i_dut
    (
        .clk(clk),
        .arst_n(arst_n),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .rx_done(rx_done),
        .rx_shift_reg(rx_shift_reg),
        .rx_parity(rx_parity),
        .err_sample(err_sample),
        .line_in(line_in),
        .tx_load(tx_load),
        .tx_holding_reg(tx_holding_reg),
        .tx_valid(tx_valid),
        .rx_enable_bit(rx_enable_bit),
        .tx_enable_bit(tx_enable_bit),
        .rx_halt(rx_halt),
        .tx_block(tx_block),
        .irq(irq)
    );
    scsf_card i_card
    (
        .clk(clk),
        .c_send(c_send),
        .c_sig(c_sig),
        .c_nak(c_nak),
        .c_bad(c_bad),
        .c_odd(c_odd),
        .c_rdy(c_rdy),
        .c_data(c_data),
        .tx_valid(tx_valid),
        .tx_block(tx_block),
        .rx_done(rx_done),
        .rx_shift_reg(rx_shift_reg),
        .rx_parity(rx_parity),
        .err_sample(err_sample),
        .line_in(line_in),
        .tx_load(tx_load)
    );
    always #12.5 clk = ~clk;
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // Ends a hung run.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        if (g !== e)
            err_total++;
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Reads one register and compares the answer in its only valid cycle.
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rc
    // One card byte, or one error-signal sample when snd is low.
    task automatic card(input logic snd, input logic nk, input logic bd, input logic [7:0] d);
        @(posedge clk);
        c_send <= snd;
        c_sig  <= !snd;
        c_nak  <= nk;
        c_bad  <= bd;
        c_data <= d;
        @(posedge clk);
        c_send <= 1'b0;
        c_sig  <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : card
    task automatic t_main;
        rc(ST, 8'h10);
        rc(3'h7, 8'h00);
        wr(CT, 8'h01);
        rc(CT, 8'h01);
        chk({6'h0, tx_enable_bit, rx_enable_bit}, 8'h01);
        card(1'b1, 1'b0, 1'b0, 8'ha5);
        rc(ST, 8'h18);
        rc(RX, 8'ha5);
        chk({7'h0, irq}, 8'h00);
        card(1'b1, 1'b0, 1'b0, 8'h3c);
        rc(ST, 8'h1c);
        rc(RX, 8'ha5);
        chk({7'h0, rx_halt}, 8'h01);
        card(1'b1, 1'b0, 1'b1, 8'h77);
        rc(ST, 8'h1c);
        wr(CT, 8'h00);
        rc(ST, 8'h1c);
        chk({6'h0, tx_enable_bit, rx_enable_bit}, 8'h00);
        chk({7'h0, rx_halt}, 8'h01);
        wr(ST, 8'hff);
        wr(ST, 8'h00);
        rc(ST, 8'h1c);
        wr(ST, 8'hfb);
        rc(ST, 8'h18);
        wr(ST, 8'hf7);
        rc(ST, 8'h10);
        chk({7'h0, rx_halt}, 8'h00);
        $display("test overrun done");
    endtask : t_main
    task automatic t_par;
        c_odd <= 1'b1;
        wr(CT, 8'h05);
        card(1'b1, 1'b0, 1'b1, 8'h96);
        rc(ST, 8'h11);
        rc(RX, 8'h96);
        wr(CT, 8'h0d);
        @(posedge clk);
        #1 chk({7'h0, tx_block}, 8'h01);
        wr(ST, 8'hfe);
        card(1'b1, 1'b0, 1'b0, 8'h96);
        rc(ST, 8'h18);
        $display("test parity done");
    endtask : t_par
    task automatic t_ers;
        wr(IM, 8'h02);
        wr(CT, 8'h02);
        card(1'b0, 1'b0, 1'b0, 8'h00);
        rc(ST, 8'h18);
        card(1'b0, 1'b1, 1'b0, 8'h00);
        rc(ST, 8'h1a);
        chk({7'h0, irq}, 8'h01);
        rc(IM, 8'h02);
        rc(IS, 8'h0f);
        wr(CT, 8'h00);
        rc(ST, 8'h1a);
        wr(IS, 8'h02);
        @(posedge clk);
        #1 chk({7'h0, irq}, 8'h00);
        rc(IS, 8'h0d);
        $display("test error signal done");
    endtask : t_ers
    task automatic t_tx;
        wr(CT, 8'h02);
        wr(TX, 8'h5a);
        #1 chk({7'h0, tx_valid}, 8'h01);
        rc(TX, 8'h5a);
        chk(tx_holding_reg, 8'h5a);
        c_rdy <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk({7'h0, tx_valid}, 8'h00);
        wr(CT, 8'h00);
        wr(TX, 8'h11);
        #1 chk({7'h0, tx_valid}, 8'h00);
        $display("test transmit done");
    endtask : t_tx
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_main();
        t_par();
        t_ers();
        t_tx();
        summarize();
    end
endmodule : scsf_top_test
